// ==== design/atdo_regs.vh ====
// Purpose: Constants for the alert tone detect output block.
// Assumes: 25 MHz system clock, APB with 32-bit data.
// Notes: Times are in microseconds; cycle counts derive from them.
`ifndef ATDO_REGS_VH
`define ATDO_REGS_VH

// ******************************
// Clock and timing
// ******************************
`define ATDO_CLK_MHZ 25
`define ATDO_TICK_US 1
`define ATDO_TICK_CYC (`ATDO_CLK_MHZ * `ATDO_TICK_US)
`define ATDO_PULSE_US 416
`define ATDO_MIN_DETECT_US 20000
`define ATDO_EARLY_US 90000
`define ATDO_OFFHOOK_GAP_US 8000
`define ATDO_OFFHOOK_MAX_US 35000
`define ATDO_ONHOOK_GAP_RST 20'h07530

// ******************************
// Function select codes {c,b}
// ******************************
`define ATDO_FUNC_FSK 2'b00
`define ATDO_FUNC_OFFHOOK 2'b01
`define ATDO_FUNC_ONHOOK 2'b10
`define ATDO_FUNC_PWRDN 2'b11

// ******************************
// Register byte offsets
// ******************************
`define ATDO_OFS_CTRL 12'h000
`define ATDO_OFS_STATUS 12'h004
`define ATDO_OFS_INT_STAT 12'h008
`define ATDO_OFS_INT_MASK 12'h00C
`define ATDO_OFS_ONHOOK_GAP 12'h010
`define ATDO_OFS_DET_COUNT 12'h014

// ******************************
// Fields and reset values
// ******************************
`define ATDO_CTRL_ENABLE 0
`define ATDO_CTRL_EARLY 1
`define ATDO_CTRL_RST 2'h3
`define ATDO_INT_DET 0
`define ATDO_INT_EARLY 1
`define ATDO_INT_MODE 2
`define ATDO_INT_W 3
`define ATDO_INT_RST 3'h0
`define ATDO_TIMER_W 20

`endif

// ==== design/atdo_sync.v ====
// Purpose: Two-stage synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps

module atdo_sync #(
    parameter W = 4
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule // atdo_sync

// ==== design/atdo_top.v ====
// Purpose: Alert tone detect control, timing and shared output pin.
// Assumes: Tone filters give a digital tone-present level per input.
// Notes: Registers on APB, zero wait states, one level interrupt.
`timescale 1ns/1ps
`include "atdo_regs.vh"

module atdo_top #(
    parameter P_PULSE_US = `ATDO_PULSE_US,
    parameter P_MIN_DETECT_US = `ATDO_MIN_DETECT_US,
    parameter P_EARLY_US = `ATDO_EARLY_US,
    parameter P_OFFHOOK_GAP_US = `ATDO_OFFHOOK_GAP_US
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_func_select_b,
    input wire i_func_select_c,
    input wire i_line_side_input,
    input wire i_hybrid_side_input,
    input wire i_byte_ready_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    output reg o_shared_ready_detect_pin,
    output reg o_fsk_power_en,
    output reg o_tone_power_en,
    output reg o_line_to_fsk,
    output reg o_line_to_tone,
    output reg o_hybrid_to_tone,
    output wire o_irq
);

    // ******************************
    // Constants
    // ******************************
    localparam [`ATDO_TIMER_W-1:0] PULSE_TICKS =
        P_PULSE_US / `ATDO_TICK_US;
    localparam [`ATDO_TIMER_W-1:0] MIN_TICKS =
        P_MIN_DETECT_US / `ATDO_TICK_US;
    localparam [`ATDO_TIMER_W-1:0] EARLY_TICKS =
        P_EARLY_US / `ATDO_TICK_US;
    localparam [`ATDO_TIMER_W-1:0] OFF_GAP_TICKS =
        P_OFFHOOK_GAP_US / `ATDO_TICK_US;
    localparam [4:0] TICK_LAST = `ATDO_TICK_CYC - 1;

    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_TONE = 5'b00010;
    localparam [4:0] ST_QUAL = 5'b00100;
    localparam [4:0] ST_GAP = 5'b01000;
    localparam [4:0] ST_PULSE = 5'b10000;

    // ******************************
    // Pin synchronisers
    // ******************************
    wire [3:0] pins_s;

    atdo_sync #(
        .W(4)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_async({i_hybrid_side_input, i_line_side_input,
                  i_func_select_c, i_func_select_b}),
        .o_sync(pins_s)
    );

    wire [1:0] func_sel = pins_s[1:0];
    wire line_s = pins_s[2];
    wire hybrid_s = pins_s[3];

    // ******************************
    // Registers and state
    // ******************************
    reg [1:0] ctrl_r;
    reg [`ATDO_INT_W-1:0] int_stat_r;
    reg [`ATDO_INT_W-1:0] int_mask_r;
    reg [`ATDO_TIMER_W-1:0] onhook_gap_r;
    reg [15:0] det_count_r;
    reg [1:0] func_r;
    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [4:0] presc_r;
    reg [`ATDO_TIMER_W-1:0] timer_r;
    reg early_r;
    reg early_nxt;

    function is_tone_func;
        input [1:0] f;
        begin
            is_tone_func = (f == `ATDO_FUNC_OFFHOOK) ||
                           (f == `ATDO_FUNC_ONHOOK);
        end
    endfunction

    wire offhook = (func_r == `ATDO_FUNC_OFFHOOK);
    wire onhook = (func_r == `ATDO_FUNC_ONHOOK);
    wire det_on = ctrl_r[`ATDO_CTRL_ENABLE] && is_tone_func(func_r);
    wire mode_chg = (func_sel != func_r);

    // Only the path of the chosen mode reaches the detector
    wire tone_in = (offhook && hybrid_s) ||
                   (onhook && line_s);

    // Off-hook hangover is fixed below 35 ms, on-hook is software's
    wire [`ATDO_TIMER_W-1:0] gap_limit =
        offhook ? OFF_GAP_TICKS : onhook_gap_r;

    // ******************************
    // Detection sequencer
    // ******************************
    wire restart = (state_nxt != state_r);
    wire tick = (presc_r == TICK_LAST);

    always @* begin
        state_nxt = state_r;
        early_nxt = early_r;
        case (state_r)
            ST_IDLE: begin
                early_nxt = 1'b0;
                if (tone_in) begin
                    state_nxt = ST_TONE;
                end
            end
            ST_TONE: begin
                if (!tone_in) begin
                    state_nxt = ST_IDLE;
                end else if (tick && timer_r >= MIN_TICKS - 1'b1) begin
                    state_nxt = ST_QUAL;
                end
            end
            ST_QUAL: begin
                if (!tone_in) begin
                    state_nxt = ST_GAP;
                end else if (ctrl_r[`ATDO_CTRL_EARLY] && tick &&
                             timer_r >= EARLY_TICKS - 1'b1) begin
                    state_nxt = ST_PULSE;
                    early_nxt = 1'b1;
                end
            end
            ST_GAP: begin
                if (tone_in) begin
                    state_nxt = ST_QUAL;
                end else if (tick && timer_r >= gap_limit) begin
                    state_nxt = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (tick && timer_r == PULSE_TICKS - 1'b1) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!det_on || mode_chg) begin
            state_nxt = ST_IDLE;
            early_nxt = 1'b0;
        end
    end

    // Prescaler restarts on every state change, so the pulse is exact
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_IDLE;
            early_r <= 1'b0;
            presc_r <= 5'h00;
            timer_r <= {`ATDO_TIMER_W{1'b0}};
            func_r <= `ATDO_FUNC_PWRDN;
        end else begin
            state_r <= state_nxt;
            early_r <= early_nxt;
            func_r <= func_sel;
            if (restart || tick) begin
                presc_r <= 5'h00;
            end else begin
                presc_r <= presc_r + 5'h01;
            end
            if (restart) begin
                timer_r <= {`ATDO_TIMER_W{1'b0}};
            end else if (tick && timer_r != {`ATDO_TIMER_W{1'b1}}) begin
                timer_r <= timer_r + 1'b1;
            end
        end
    end

    wire pulse_start = (state_nxt == ST_PULSE) && (state_r != ST_PULSE);

    // ******************************
    // Pin and power outputs
    // ******************************
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_shared_ready_detect_pin <= 1'b1;
            o_fsk_power_en <= 1'b0;
            o_tone_power_en <= 1'b0;
            o_line_to_fsk <= 1'b0;
            o_line_to_tone <= 1'b0;
            o_hybrid_to_tone <= 1'b0;
        end else begin
            if (is_tone_func(func_r)) begin
                o_shared_ready_detect_pin <=
                    (state_nxt != ST_PULSE);
            end else if (func_r == `ATDO_FUNC_FSK) begin
                o_shared_ready_detect_pin <= i_byte_ready_n;
            end else begin
                o_shared_ready_detect_pin <= 1'b1;
            end
            o_fsk_power_en <= (func_r == `ATDO_FUNC_FSK);
            o_tone_power_en <= is_tone_func(func_r);
            o_line_to_fsk <= (func_r == `ATDO_FUNC_FSK);
            o_line_to_tone <= onhook;
            o_hybrid_to_tone <= offhook;
        end
    end

    // ******************************
    // APB slave
    // ******************************
    wire setup = i_psel && !i_penable;
    wire access = i_psel && i_penable;

    function addr_ok;
        input [11:0] a;
        begin
            addr_ok = (a == `ATDO_OFS_CTRL) || (a == `ATDO_OFS_STATUS) ||
                      (a == `ATDO_OFS_INT_STAT) ||
                      (a == `ATDO_OFS_INT_MASK) ||
                      (a == `ATDO_OFS_ONHOOK_GAP) ||
                      (a == `ATDO_OFS_DET_COUNT);
        end
    endfunction

    // Zero wait states; read data is latched in the setup cycle
    assign o_pready = 1'b1;
    assign o_pslverr = access && !addr_ok(i_paddr);

    wire wr = access && i_pwrite;
    wire [`ATDO_INT_W-1:0] ev = {mode_chg,
                                 pulse_start && early_nxt,
                                 pulse_start};

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
        end else if (setup && !i_pwrite) begin
            case (i_paddr)
                `ATDO_OFS_CTRL: o_prdata <= {30'h0, ctrl_r};
                `ATDO_OFS_STATUS: o_prdata <= {22'h0, early_r, state_r,
                                               tone_in, det_on, func_r};
                `ATDO_OFS_INT_STAT: o_prdata <= {29'h0, int_stat_r};
                `ATDO_OFS_INT_MASK: o_prdata <= {29'h0, int_mask_r};
                `ATDO_OFS_ONHOOK_GAP: o_prdata <= {12'h0, onhook_gap_r};
                `ATDO_OFS_DET_COUNT: o_prdata <= {16'h0, det_count_r};
                default: o_prdata <= 32'h00000000;
            endcase
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= `ATDO_CTRL_RST;
            int_mask_r <= `ATDO_INT_RST;
            int_stat_r <= `ATDO_INT_RST;
            onhook_gap_r <= `ATDO_ONHOOK_GAP_RST;
            det_count_r <= 16'h0000;
        end else begin
            if (wr && i_paddr == `ATDO_OFS_CTRL) begin
                ctrl_r <= i_pwdata[1:0];
            end
            if (wr && i_paddr == `ATDO_OFS_INT_MASK) begin
                int_mask_r <= i_pwdata[`ATDO_INT_W-1:0];
            end
            if (wr && i_paddr == `ATDO_OFS_ONHOOK_GAP) begin
                onhook_gap_r <= i_pwdata[`ATDO_TIMER_W-1:0];
            end
            // New events win over a write-one clear in the same cycle
            if (wr && i_paddr == `ATDO_OFS_INT_STAT) begin
                int_stat_r <= (int_stat_r & ~i_pwdata[`ATDO_INT_W-1:0]) | ev;
            end else begin
                int_stat_r <= int_stat_r | ev;
            end
            if (wr && i_paddr == `ATDO_OFS_DET_COUNT) begin
                det_count_r <= 16'h0000;
            end else if (pulse_start) begin
                det_count_r <= det_count_r + 16'h0001;
            end
        end
    end

    assign o_irq = |(int_stat_r & int_mask_r);

endmodule // atdo_top

// ==== verification/atdo_checker.sv ====
// Purpose: Assertions on the pins of the alert tone detect block.
// Assumes: Tone inputs may go high in any mode; age follows the one o_hybrid_to_tone picks.
// Notes: Helper counters measure pulse width and time since tone rise.
`timescale 1ns/1ps
module atdo_checker #(
    parameter P_PULSE_US = 416,
    parameter P_MIN_DETECT_US = 20000
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_func_select_b,
    input wire i_func_select_c,
    input wire i_line_side_input,
    input wire i_hybrid_side_input,
    input wire i_byte_ready_n,
    input wire i_psel,
    input wire i_penable,
    input wire [11:0] i_paddr,
    input wire o_pslverr,
    input wire o_shared_ready_detect_pin,
    input wire o_fsk_power_en,
    input wire o_tone_power_en,
    input wire o_line_to_fsk,
    input wire o_line_to_tone,
    input wire o_hybrid_to_tone
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    localparam int PULSE_CYC = P_PULSE_US * 25;
    localparam int MIN_CYC = P_MIN_DETECT_US * 25;
    // ****************************************
    // Helper counters
    // ****************************************
    reg [15:0] low_cnt_r;
    reg [23:0] age_r;
    reg sel_r;
    wire sel_tone;
    assign sel_tone = o_hybrid_to_tone ? i_hybrid_side_input
                                       : i_line_side_input;
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt_r <= 16'h0000;
            age_r <= 24'h000000;
            sel_r <= 1'b0;
        end else begin
            sel_r <= sel_tone;
            low_cnt_r <= o_shared_ready_detect_pin ? 16'h0000
                                                   : low_cnt_r + 16'h0001;
            // Saturate so a long idle never wraps into a false young age
            if (sel_tone && !sel_r)
                age_r <= 24'h000000;
            else if (age_r != 24'hFFFFFF)
                age_r <= age_r + 24'h000001;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_power_split;
        !(o_fsk_power_en && o_tone_power_en);
    endproperty
    a_power_split: assert property (p_power_split)
        else $error("fsk and tone powered together");
    property p_hybrid_route;
        o_hybrid_to_tone |-> !o_line_to_tone && !o_line_to_fsk
                             && o_tone_power_en;
    endproperty
    a_hybrid_route: assert property (p_hybrid_route)
        else $error("hybrid path not alone");
    property p_fsk_route;
        o_line_to_fsk == o_fsk_power_en;
    endproperty
    a_fsk_route: assert property (p_fsk_route)
        else $error("fsk route and power differ");
    property p_pwrdn_high;
        (i_func_select_b && i_func_select_c) [*5]
            |-> o_shared_ready_detect_pin;
    endproperty
    a_pwrdn_high: assert property (p_pwrdn_high)
        else $error("pin low in power down");
    property p_fsk_copy;
        (!i_func_select_b && !i_func_select_c) [*5]
            |-> o_shared_ready_detect_pin == $past(i_byte_ready_n);
    endproperty
    a_fsk_copy: assert property (p_fsk_copy)
        else $error("pin not byte ready in fsk");
    property p_pulse_width;
        $rose(o_shared_ready_detect_pin) && o_tone_power_en
            && $past(o_tone_power_en) |-> low_cnt_r == PULSE_CYC;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("detect pulse width wrong");
    property p_min_delay;
        $fell(o_shared_ready_detect_pin) && o_tone_power_en
            |-> age_r >= MIN_CYC;
    endproperty
    a_min_delay: assert property (p_min_delay)
        else $error("detect before minimum delay");
    property p_bus_error;
        i_psel && i_penable && i_paddr > 12'h014 |-> o_pslverr;
    endproperty
    a_bus_error: assert property (p_bus_error)
        else $error("unmapped access without error");
endmodule // atdo_checker

// ==== verification/atdo_far_end.sv ====
// Purpose: Host pins and tone filter levels facing the block.
// Assumes: Called from the bench; drives on rising edges only.
// Notes: Waits 8 cycles after a select change for it to land.
`timescale 1ns/1ps
module atdo_far_end (
    input wire i_clk_sys,
    output reg o_func_select_b,
    output reg o_func_select_c,
    output reg o_line_tone,
    output reg o_hybrid_tone,
    output reg o_byte_ready_n
);
    initial begin
        {o_func_select_c, o_func_select_b} = 2'h3;
        {o_line_tone, o_hybrid_tone, o_byte_ready_n} = 3'h1;
    end
    // Host picks one of the four functions, {c,b}
    task set_func(input [1:0] f);
        @(posedge i_clk_sys);
        {o_func_select_c, o_func_select_b} <= f;
        repeat (8) @(posedge i_clk_sys);
    endtask
    task send_tone(input hyb, input integer cyc);
        @(posedge i_clk_sys);
        o_hybrid_tone <= hyb;
        o_line_tone <= !hyb;
        repeat (cyc) @(posedge i_clk_sys);
        o_hybrid_tone <= 1'b0;
        o_line_tone <= 1'b0;
    endtask
    task set_ready(input v);
        @(posedge i_clk_sys);
        o_byte_ready_n <= v;
    endtask
endmodule // atdo_far_end

// ==== verification/tb_atdo_top.sv ====
// Purpose: Self-checking bench for the alert tone detect block.
// Assumes: Short timing parameters; tick of 25 cycles.
// Notes: Pulse is 4 us, minimum detect 50 us, off-hook gap 20 us.
`timescale 1ns/1ps
module tb_atdo_top;
    localparam int T = 25;
    reg clk = 1'b0;
    reg rst_n;
    reg psel;
    reg pen;
    reg pwr;
    reg [11:0] paddr;
    reg [31:0] pwdata;
    reg [31:0] rd;
    reg err;
    wire [31:0] prdata;
    wire pready, pslverr, pin, fpe, tpe, l2f, l2t, h2t, irq;
    wire fb, fc, lt, ht, brn;
    integer mismatches = 0;
    integer checks_done = 0;
    integer n;
    atdo_far_end u_atdo_far_end (.i_clk_sys(clk), .o_func_select_b(fb),
        .o_func_select_c(fc), .o_line_tone(lt), .o_hybrid_tone(ht),
        .o_byte_ready_n(brn));
    atdo_top #(.P_PULSE_US(4), .P_MIN_DETECT_US(50), .P_EARLY_US(200),
        .P_OFFHOOK_GAP_US(20)) u_atdo_top (.i_clk_sys(clk),
        .i_rst_n(rst_n), .i_func_select_b(fb), .i_func_select_c(fc),
        .i_line_side_input(lt), .i_hybrid_side_input(ht),
        .i_byte_ready_n(brn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_shared_ready_detect_pin(pin), .o_fsk_power_en(fpe),
        .o_tone_power_en(tpe), .o_line_to_fsk(l2f), .o_line_to_tone(l2t),
        .o_hybrid_to_tone(h2t), .o_irq(irq));
    initial begin
        forever #20 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks_done = checks_done + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 50) begin
            k = k + 1;
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        // Let the write land before callers look at outputs
        @(negedge clk);
        if (k == 50) begin
            mismatches = mismatches + 1;
            complete_run();
        end
    endtask
    task rchk(input string nm, input [11:0] a, input [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask
    task wait_fall(input integer lim);
        n = 0;
        while (pin !== 1'b0 && n < lim) begin
            @(negedge clk);
            n = n + 1;
        end
    endtask
    task width_chk;
        n = 0;
        while (pin === 1'b0 && n < 20000) begin
            @(negedge clk);
            n = n + 1;
        end
        chk("pulse width", 100, n);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        rst_n <= 1'b0;
        psel <= 1'b0;
        pen <= 1'b0;
        pwr <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h00000000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rchk("ctrl", 12'h000, 32'h00000003);
        rchk("mask", 12'h00C, 32'h00000000);
        rchk("gap", 12'h010, 32'h00007530);
        rchk("unmapped", 12'h020, 32'h00000000);
        chk("slverr", 1, err);
        u_atdo_far_end.set_func(2'h1);
        chk("offhook route", 5'h09, {fpe, tpe, l2f, l2t, h2t});
        apb(1'b1, 12'h008, 32'h00000007);
        u_atdo_far_end.send_tone(1'b1, 30 * T);
        wait_fall(3000);
        chk("short tone", 3000, n);
        u_atdo_far_end.send_tone(1'b0, 60 * T);
        wait_fall(3000);
        chk("line ignored", 3000, n);
        u_atdo_far_end.send_tone(1'b1, 60 * T);
        wait_fall(2000);
        chk("late bound", 1, n >= 475 && n <= 560);
        width_chk();
        chk("irq masked", 0, irq);
        apb(1'b1, 12'h00C, 32'h00000001);
        chk("irq", 1, irq);
        apb(1'b1, 12'h008, 32'h00000001);
        chk("irq cleared", 0, irq);
        $display("offhook test done");
        u_atdo_far_end.send_tone(1'b1, 300 * T);
        rchk("early flags", 12'h008, 32'h00000003);
        apb(1'b1, 12'h000, 32'h00000002);
        u_atdo_far_end.send_tone(1'b1, 60 * T);
        wait_fall(3000);
        chk("disabled", 3000, n);
        apb(1'b1, 12'h000, 32'h00000003);
        apb(1'b1, 12'h010, 32'h0000000A);
        u_atdo_far_end.set_func(2'h2);
        chk("onhook route", 5'h0A, {fpe, tpe, l2f, l2t, h2t});
        u_atdo_far_end.send_tone(1'b1, 60 * T);
        wait_fall(3000);
        chk("hybrid ignored", 3000, n);
        u_atdo_far_end.send_tone(1'b0, 60 * T);
        wait_fall(2000);
        chk("onhook detect", 1, n < 2000);
        width_chk();
        rchk("count", 12'h014, 32'h00000003);
        $display("onhook test done");
        u_atdo_far_end.set_func(2'h0);
        chk("fsk route", 5'h14, {fpe, tpe, l2f, l2t, h2t});
        u_atdo_far_end.set_ready(1'b0);
        repeat (3) @(negedge clk);
        chk("ready copy", 0, pin);
        u_atdo_far_end.set_ready(1'b1);
        u_atdo_far_end.send_tone(1'b0, 60 * T);
        wait_fall(3000);
        chk("fsk no detect", 3000, n);
        u_atdo_far_end.set_func(2'h3);
        chk("pwrdn route", 0, {fpe, tpe, l2f, l2t, h2t});
        $display("fsk test done");
        complete_run();
    end
endmodule // tb_atdo_top

bind atdo_top atdo_checker #(.P_PULSE_US(P_PULSE_US),
    .P_MIN_DETECT_US(P_MIN_DETECT_US)) u_atdo_checker (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_func_select_b(i_func_select_b), .i_func_select_c(i_func_select_c),
    .i_line_side_input(i_line_side_input),
    .i_hybrid_side_input(i_hybrid_side_input),
    .i_byte_ready_n(i_byte_ready_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_pslverr(o_pslverr),
    .o_shared_ready_detect_pin(o_shared_ready_detect_pin),
    .o_fsk_power_en(o_fsk_power_en), .o_tone_power_en(o_tone_power_en),
    .o_line_to_fsk(o_line_to_fsk), .o_line_to_tone(o_line_to_tone),
    .o_hybrid_to_tone(o_hybrid_to_tone));
